// ---- swp_host.sv ----
// Notes on behaviour
// - unlock commands spaced 1 us apart
// - pin held steady during a command
// - set lock early, pin low for boot; the host resets the pin high
// - set lock after persistent guards final
// - verify password only while programming
`timescale 1ns/10ps
`default_nettype none
module swp_host #(
   parameter int UNLOCK_GAP_CYC = swp_pkg::SWP_UNLOCK_GAP_CYC,
   parameter int BUS_CYC = swp_pkg::SWP_BUS_CYC
) (
   input wire logic ref_clk_i, // clock
   input wire logic rst_n_i, // sync reset, active low
   input wire swp_pkg::swp_cmd_t cmd_i, // software register port
   output logic [31:0] rdata_o, // read data, cycle after read
   input wire logic [15:0] fl_dq_i, // flash data in
   output logic [7:0] fl_op_o, // flash op code
   output logic [15:0] fl_sector_o, // flash sector address
   output logic [1:0] fl_word_sel_o, // password_word_select
   output logic [15:0] fl_dq_o, // flash data out
   output logic fl_dq_oe_o, // flash data drive enable
   output logic fl_we_n_o, // flash write strobe
   output logic write_protect_accel_pin_o, // pin level, low guards outer sector
   output logic busy_o // command running
);
   import swp_pkg::*;
   initial begin
      if (UNLOCK_GAP_CYC < 1 || UNLOCK_GAP_CYC > 65535) $error("swp_host: bad UNLOCK_GAP_CYC");
   end

   swp_state_t st_reg, st_next;
   logic [3:0] cmd_reg, cmd_next;
   logic [15:0] sector_reg, sector_next;
   logic [15:0] pw_reg [SWP_PW_WORDS], pw_next [SWP_PW_WORDS];
   logic [1:0] widx_reg, widx_next;
   logic [15:0] gap_reg, gap_next;
   logic [1:0] res_reg, res_next;
   logic [15:0] stat_reg, stat_next;
   logic wp_reg, wp_next, mode_pw_reg, mode_pw_next, mode_pers_reg, mode_pers_next;
   logic busy_reg, busy_next, pw_set_reg, pw_set_next;
   logic [31:0] rdata_reg, rdata_next;
   logic bus_start, bus_busy, bus_done;
   logic [15:0] bus_rdata;
   swp_flash_req_t req;

   function automatic logic [7:0] op_of(input logic [3:0] c);
      case (c)
         SWP_CMD_VOL_SET: op_of = SWP_OP_SET_VOL;
         SWP_CMD_VOL_CLR: op_of = SWP_OP_CLR_VOL;
         SWP_CMD_VOL_RD: op_of = SWP_OP_RD_VOL;
         SWP_CMD_PERS_RD: op_of = SWP_OP_RD_PERS;
         SWP_CMD_LOCK_RD: op_of = SWP_OP_RD_LOCK;
         SWP_CMD_LOCK_SET: op_of = SWP_OP_SET_LOCK;
         SWP_CMD_PW_UNLOCK: op_of = SWP_OP_UNLOCK;
         SWP_CMD_PW_PROG: op_of = SWP_OP_PW_PROG;
         SWP_CMD_PERS_PROG: op_of = SWP_OP_PROG_PERS;
         SWP_CMD_PERS_ERASE: op_of = SWP_OP_ERASE_PERS;
         SWP_CMD_MODE_PROG: op_of = SWP_OP_MODE_PROG;
         default: op_of = SWP_OP_PROG_ARRAY;
      endcase
   endfunction

   // multi-word commands walk all password words
   function automatic logic multi(input logic [3:0] c);
      multi = (c == SWP_CMD_PW_UNLOCK) || (c == SWP_CMD_PW_PROG);
   endfunction

   always_comb begin
      req.op = op_of(cmd_reg);
      req.sector = sector_reg;
      req.word_sel = widx_reg;
      // mode select bits sit at data bits 2 and 1, active low; bit 0 left erased
      if (cmd_reg == SWP_CMD_MODE_PROG)
         req.data = {13'h0000, ~mode_pw_reg, ~mode_pers_reg, 1'b1};
      else
         req.data = pw_reg[widx_reg];
   end

   always_comb begin
      st_next = st_reg;
      cmd_next = cmd_reg;
      sector_next = sector_reg;
      pw_next = pw_reg;
      widx_next = widx_reg;
      gap_next = (gap_reg != 16'h0000) ? gap_reg - 16'h0001 : gap_reg;
      res_next = res_reg;
      stat_next = stat_reg;
      wp_next = wp_reg;
      mode_pw_next = mode_pw_reg;
      mode_pers_next = mode_pers_reg;
      pw_set_next = pw_set_reg;
      rdata_next = 32'h0000_0000;
      bus_start = 1'b0;
      if (cmd_i.rd) begin
         if (cmd_i.addr == SWP_REG_CTRL)
            rdata_next = {24'h000000, mode_pw_reg, mode_pers_reg, wp_reg, 1'b0, cmd_reg};
         else if (cmd_i.addr == SWP_REG_SECTOR)
            rdata_next = {16'h0000, sector_reg};
         else if (cmd_i.addr == SWP_REG_STATUS)
            rdata_next = {29'h0, st_reg != SWP_IDLE, res_reg};
         else if (cmd_i.addr == SWP_REG_RESULT)
            rdata_next = {16'h0000, stat_reg};
         else
            rdata_next = 32'h0000_0000; // password is write-only from software
      end
      if (cmd_i.wr) begin
         if (cmd_i.addr == SWP_REG_SECTOR)
            sector_next = cmd_i.wdata[15:0];
         else if (cmd_i.addr >= SWP_REG_PW0 && cmd_i.addr <= SWP_REG_PW3)
            pw_next[2'(cmd_i.addr - SWP_REG_PW0)] = cmd_i.wdata[15:0];
      end
      case (st_reg)
         SWP_IDLE: begin
            if (cmd_i.wr && cmd_i.addr == SWP_REG_CTRL) begin
               // pin only moves between commands
               wp_next = cmd_i.wdata[5];
               mode_pers_next = cmd_i.wdata[6];
               mode_pw_next = cmd_i.wdata[7];
               if (cmd_i.wdata[3:0] != SWP_CMD_NONE) begin
                  cmd_next = cmd_i.wdata[3:0];
                  widx_next = 2'h0;
                  if (cmd_i.wdata[3:0] == SWP_CMD_MODE_PROG && cmd_i.wdata[7] && cmd_i.wdata[6]) begin
                     res_next = SWP_RES_ABORT;
                     st_next = SWP_DONE;
                  end else if (cmd_i.wdata[3:0] == SWP_CMD_PW_UNLOCK && gap_reg != 16'h0000) begin
                     res_next = SWP_RES_REFUSED;
                     st_next = SWP_DONE;
                  end else if (cmd_i.wdata[3:0] == SWP_CMD_MODE_PROG && cmd_i.wdata[7] && !pw_set_reg) begin
                     // password mode is final, so never select it before a password went in
                     res_next = SWP_RES_REFUSED;
                     st_next = SWP_DONE;
                  end else begin
                     res_next = SWP_RES_OK;
                     st_next = SWP_ISSUE;
                  end
               end
            end
         end
         SWP_ISSUE: begin
            if (!bus_busy) begin
               bus_start = 1'b1;
               st_next = SWP_WAIT;
            end
         end
         SWP_WAIT: begin
            if (bus_done) begin
               stat_next = bus_rdata;
               if (multi(cmd_reg) && widx_reg != 2'(SWP_PW_WORDS - 1)) begin
                  widx_next = widx_reg + 2'h1;
                  if (bus_rdata[0])
                     res_next = SWP_RES_TIMEOUT;
                  st_next = SWP_ISSUE;
               end else begin
                  // device answers bit 0 set on time-out or refusal
                  // one failed word of a password command fails the whole command
                  if (bus_rdata[0] || (multi(cmd_reg) && res_reg == SWP_RES_TIMEOUT))
                     res_next = SWP_RES_TIMEOUT;
                  else
                     res_next = SWP_RES_OK;
                  if (cmd_reg == SWP_CMD_PW_PROG && res_next == SWP_RES_OK)
                     pw_set_next = 1'b1;
                  if (cmd_reg == SWP_CMD_PW_UNLOCK) begin
                     gap_next = 16'(UNLOCK_GAP_CYC);
                     st_next = SWP_GAP;
                  end else begin
                     st_next = SWP_DONE;
                  end
               end
            end
         end
         SWP_GAP: begin
            // hold busy while the device finishes the unlock
            if (gap_reg == 16'h0001)
               st_next = SWP_DONE;
         end
         SWP_DONE: begin
            cmd_next = SWP_CMD_NONE;
            st_next = SWP_IDLE;
         end
         default: st_next = SWP_IDLE;
      endcase
      busy_next = (st_next != SWP_IDLE);
   end

   always_ff @(posedge ref_clk_i) begin
      if (!rst_n_i) begin
         st_reg <= SWP_IDLE;
         cmd_reg <= SWP_CMD_NONE;
         sector_reg <= 16'h0000;
         for (int i = 0; i < SWP_PW_WORDS; i++)
            pw_reg[i] <= 16'hFFFF;
         widx_reg <= 2'h0;
         gap_reg <= 16'h0000;
         res_reg <= SWP_RES_OK;
         stat_reg <= 16'h0000;
         wp_reg <= 1'b1;
         mode_pw_reg <= 1'b0;
         mode_pers_reg <= 1'b0;
         busy_reg <= 1'b0;
         pw_set_reg <= 1'b0;
         rdata_reg <= 32'h0000_0000;
      end else begin
         st_reg <= st_next;
         cmd_reg <= cmd_next;
         sector_reg <= sector_next;
         pw_reg <= pw_next;
         widx_reg <= widx_next;
         gap_reg <= gap_next;
         res_reg <= res_next;
         stat_reg <= stat_next;
         wp_reg <= wp_next;
         mode_pw_reg <= mode_pw_next;
         mode_pers_reg <= mode_pers_next;
         busy_reg <= busy_next;
         pw_set_reg <= pw_set_next;
         rdata_reg <= rdata_next;
      end
   end

   swp_bus_cycle #(.CYC(BUS_CYC)) u_bus (
      .ref_clk_i(ref_clk_i),
      .rst_n_i(rst_n_i),
      .start_i(bus_start),
      .req_i(req),
      .fl_dq_i(fl_dq_i),
      .fl_op_o(fl_op_o),
      .fl_sector_o(fl_sector_o),
      .fl_word_sel_o(fl_word_sel_o),
      .fl_dq_o(fl_dq_o),
      .fl_dq_oe_o(fl_dq_oe_o),
      .fl_we_n_o(fl_we_n_o),
      .busy_o(bus_busy),
      .done_o(bus_done),
      .rdata_o(bus_rdata)
   );

   assign rdata_o = rdata_reg;
   assign write_protect_accel_pin_o = wp_reg;
   assign busy_o = busy_reg;
endmodule
`default_nettype wire

// ---- swp_pkg.sv ----
package swp_pkg;
   // software register offsets (word addresses on the command port)
   localparam logic [3:0] SWP_REG_CTRL = 4'h0;
   localparam logic [3:0] SWP_REG_SECTOR = 4'h1;
   localparam logic [3:0] SWP_REG_PW0 = 4'h2;
   localparam logic [3:0] SWP_REG_PW1 = 4'h3;
   localparam logic [3:0] SWP_REG_PW2 = 4'h4;
   localparam logic [3:0] SWP_REG_PW3 = 4'h5;
   localparam logic [3:0] SWP_REG_STATUS = 4'h6;
   localparam logic [3:0] SWP_REG_RESULT = 4'h7;
   // command codes written to CTRL[3:0]
   localparam logic [3:0] SWP_CMD_NONE = 4'h0;
   localparam logic [3:0] SWP_CMD_VOL_SET = 4'h1;
   localparam logic [3:0] SWP_CMD_VOL_CLR = 4'h2;
   localparam logic [3:0] SWP_CMD_VOL_RD = 4'h3;
   localparam logic [3:0] SWP_CMD_PERS_RD = 4'h4;
   localparam logic [3:0] SWP_CMD_LOCK_RD = 4'h5;
   localparam logic [3:0] SWP_CMD_LOCK_SET = 4'h6;
   localparam logic [3:0] SWP_CMD_PW_UNLOCK = 4'h7;
   localparam logic [3:0] SWP_CMD_PW_PROG = 4'h8;
   localparam logic [3:0] SWP_CMD_PERS_PROG = 4'h9;
   localparam logic [3:0] SWP_CMD_PERS_ERASE = 4'hA;
   localparam logic [3:0] SWP_CMD_MODE_PROG = 4'hB;
   localparam logic [3:0] SWP_CMD_ARRAY_PROG = 4'hC;
   // device-side op codes presented on the flash bus
   localparam logic [7:0] SWP_OP_SET_VOL = 8'h01;
   localparam logic [7:0] SWP_OP_CLR_VOL = 8'h02;
   localparam logic [7:0] SWP_OP_RD_VOL = 8'h03;
   localparam logic [7:0] SWP_OP_RD_PERS = 8'h04;
   localparam logic [7:0] SWP_OP_RD_LOCK = 8'h05;
   localparam logic [7:0] SWP_OP_SET_LOCK = 8'h06;
   localparam logic [7:0] SWP_OP_UNLOCK = 8'h07;
   localparam logic [7:0] SWP_OP_PW_PROG = 8'h08;
   localparam logic [7:0] SWP_OP_PROG_PERS = 8'h09;
   localparam logic [7:0] SWP_OP_ERASE_PERS = 8'h0A;
   localparam logic [7:0] SWP_OP_MODE_PROG = 8'h0B;
   localparam logic [7:0] SWP_OP_PROG_ARRAY = 8'h0C;
   // timing
   localparam int SWP_CLK_MHZ = 250;
   localparam int SWP_UNLOCK_GAP_NS = 1000;
   localparam int SWP_UNLOCK_GAP_CYC = (SWP_UNLOCK_GAP_NS * SWP_CLK_MHZ + 999) / 1000;
   localparam int SWP_BUS_CYC = 4;
   localparam int SWP_PW_WORDS = 4;
   // result codes
   localparam logic [1:0] SWP_RES_OK = 2'h0;
   localparam logic [1:0] SWP_RES_REFUSED = 2'h1;
   localparam logic [1:0] SWP_RES_TIMEOUT = 2'h2;
   localparam logic [1:0] SWP_RES_ABORT = 2'h3;

   typedef struct packed {
      logic [3:0] addr;
      logic [31:0] wdata;
      logic wr;
      logic rd;
   } swp_cmd_t;

   typedef struct packed {
      logic [7:0] op;
      logic [15:0] sector;
      logic [1:0] word_sel;
      logic [15:0] data;
   } swp_flash_req_t;

   typedef enum logic [2:0] {
      SWP_IDLE = 3'b000,
      SWP_ISSUE = 3'b001,
      SWP_WAIT = 3'b011,
      SWP_GAP = 3'b010,
      SWP_DONE = 3'b110
   } swp_state_t;
endpackage

// ---- swp_bus_cycle.sv ----
`timescale 1ns/10ps
`default_nettype none
// one flash bus access: strobe held for a fixed number of cycles, then data sampled
module swp_bus_cycle #(
   parameter int CYC = 4
) (
   input wire logic ref_clk_i, // clock
   input wire logic rst_n_i, // sync reset
   input wire logic start_i, // begin access
   input wire swp_pkg::swp_flash_req_t req_i, // access contents
   input wire logic [15:0] fl_dq_i, // flash data in
   output logic [7:0] fl_op_o, // op code
   output logic [15:0] fl_sector_o, // sector address
   output logic [1:0] fl_word_sel_o, // password_word_select
   output logic [15:0] fl_dq_o, // flash data out
   output logic fl_dq_oe_o, // data drive enable
   output logic fl_we_n_o, // write strobe
   output logic busy_o, // access running
   output logic done_o, // access ended pulse
   output logic [15:0] rdata_o // sampled data
);
   import swp_pkg::*;
   initial begin
      if (CYC < 2 || CYC > 255) $error("swp_bus_cycle: CYC out of range");
   end
   logic [7:0] cnt_reg, cnt_next;
   logic busy_reg, busy_next, done_reg, done_next;
   swp_flash_req_t req_reg, req_next;
   logic [15:0] rd_reg, rd_next;

   always_comb begin
      cnt_next = cnt_reg;
      busy_next = busy_reg;
      done_next = 1'b0;
      req_next = req_reg;
      rd_next = rd_reg;
      if (!busy_reg && start_i) begin
         busy_next = 1'b1;
         req_next = req_i;
         cnt_next = 8'(CYC - 1);
      end else if (busy_reg) begin
         if (cnt_reg == 8'h00) begin
            busy_next = 1'b0;
            done_next = 1'b1;
            rd_next = fl_dq_i;
         end else begin
            cnt_next = cnt_reg - 8'h01;
         end
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (!rst_n_i) begin
         cnt_reg <= 8'h00;
         busy_reg <= 1'b0;
         done_reg <= 1'b0;
         req_reg <= '0;
         rd_reg <= 16'h0000;
      end else begin
         cnt_reg <= cnt_next;
         busy_reg <= busy_next;
         done_reg <= done_next;
         req_reg <= req_next;
         rd_reg <= rd_next;
      end
   end

   assign fl_op_o = req_reg.op;
   assign fl_sector_o = req_reg.sector;
   assign fl_word_sel_o = req_reg.word_sel;
   assign fl_dq_o = req_reg.data;
   assign fl_dq_oe_o = busy_reg;
   assign fl_we_n_o = ~busy_reg;
   assign busy_o = busy_reg;
   assign done_o = done_reg;
   assign rdata_o = rd_reg;
endmodule
`default_nettype wire

// ---- swp_host_chk.sv ----
`timescale 1ns/10ps
`default_nettype none
module swp_host_chk import swp_pkg::*; #(
   parameter int UNLOCK_GAP_CYC = SWP_UNLOCK_GAP_CYC,
   parameter int BUS_CYC = SWP_BUS_CYC
) (
   input wire logic ref_clk_i, // clock
   input wire logic rst_n_i, // sync reset
   input wire swp_pkg::swp_cmd_t cmd_i, // register port
   input wire logic [31:0] rdata_o, // read data
   input wire logic [15:0] fl_dq_i, // flash data in
   input wire logic [7:0] fl_op_o, // op code
   input wire logic [15:0] fl_sector_o, // sector
   input wire logic [1:0] fl_word_sel_o, // password_word_select
   input wire logic [15:0] fl_dq_o, // flash data out
   input wire logic fl_dq_oe_o, // drive enable
   input wire logic fl_we_n_o, // write strobe
   input wire logic write_protect_accel_pin_o, // pin level
   input wire logic busy_o // command running
);
   logic [7:0] low_reg, low_next;
   logic [15:0] gap_reg, gap_next;
   // gap saturates so long idle stretches never wrap into a false short gap
   always_comb begin
      low_next = fl_we_n_o ? 8'h00 : low_reg + 8'h01;
      gap_next = (gap_reg == 16'hFFFF) ? gap_reg : gap_reg + 16'h0001;
      if (!fl_we_n_o && low_reg == 8'h00 && fl_op_o == SWP_OP_UNLOCK && fl_word_sel_o == 2'h0) begin
         gap_next = 16'h0001;
      end
   end
   always_ff @(posedge ref_clk_i) begin
      if (!rst_n_i) begin
         low_reg <= 8'h00;
         gap_reg <= 16'hFFFF;
      end else begin
         low_reg <= low_next;
         gap_reg <= gap_next;
      end
   end
   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (!rst_n_i);
   sequence ctrl_wr;
      cmd_i.wr && cmd_i.addr == SWP_REG_CTRL && !busy_o;
   endsequence
   sequence unlock_start;
      $fell(fl_we_n_o) && fl_op_o == SWP_OP_UNLOCK && fl_word_sel_o == 2'h0;
   endsequence
   strobe_len_a: assert property ($rose(fl_we_n_o) |-> low_reg == 8'(BUS_CYC))
      else $error("write strobe length wrong");
   oe_during_a: assert property (!fl_we_n_o |-> fl_dq_oe_o)
      else $error("data not driven during access");
   pin_steady_a: assert property (busy_o && $past(busy_o) |-> $stable(write_protect_accel_pin_o))
      else $error("pin moved during command");
   fields_steady_a: assert property (!fl_we_n_o && !$past(fl_we_n_o) |->
      $stable(fl_op_o) && $stable(fl_sector_o) && $stable(fl_dq_o) && $stable(fl_word_sel_o))
      else $error("access fields moved");
   unlock_gap_a: assert property (unlock_start |-> gap_reg >= 16'(UNLOCK_GAP_CYC))
      else $error("unlock commands too close");
   access_soon_a: assert property (ctrl_wr ##0 (cmd_i.wdata[3:0] inside {[SWP_CMD_VOL_SET:SWP_CMD_LOCK_SET]})
      |-> ##[1:5] !fl_we_n_o)
      else $error("command produced no access");
   mode_abort_a: assert property (ctrl_wr ##0
      (cmd_i.wdata[3:0] == SWP_CMD_MODE_PROG && cmd_i.wdata[7:6] == 2'b11) |=> fl_we_n_o [*8])
      else $error("double mode select reached flash");
   rd_zero_a: assert property (cmd_i.rd && (cmd_i.addr > SWP_REG_RESULT ||
      cmd_i.addr inside {[SWP_REG_PW0:SWP_REG_PW3]}) |=> rdata_o == 32'h0)
      else $error("hidden register read not zero");
endmodule
bind swp_host swp_host_chk #(.UNLOCK_GAP_CYC(UNLOCK_GAP_CYC), .BUS_CYC(BUS_CYC)) u_chk (
   .ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .cmd_i(cmd_i), .rdata_o(rdata_o), .fl_dq_i(fl_dq_i),
   .fl_op_o(fl_op_o), .fl_sector_o(fl_sector_o), .fl_word_sel_o(fl_word_sel_o), .fl_dq_o(fl_dq_o),
   .fl_dq_oe_o(fl_dq_oe_o), .fl_we_n_o(fl_we_n_o),
   .write_protect_accel_pin_o(write_protect_accel_pin_o), .busy_o(busy_o));
`default_nettype wire

// ---- swp_flash_model.sv ----
`timescale 1ns/10ps
`default_nettype none
module swp_flash_model import swp_pkg::*; #(
   parameter int BUS_CYC = 4,
   parameter int GAP = 250,
   parameter logic VOL_INIT = 1'b1
) (
   input wire logic ref_clk_i, // clock
   input wire logic rst_n_i, // hardware reset
   input wire logic [7:0] op_i, // op code
   input wire logic [15:0] sector_i, // sector
   input wire logic [1:0] word_sel_i, // password_word_select
   input wire logic [15:0] dq_i, // data from host
   input wire logic we_n_i, // write strobe
   input wire logic wp_pin_i, // write_protect_accel_pin
   output logic [15:0] dq_o // data to host
);
   logic [7:0] vol, pers;
   logic [15:0] pw [4];
   logic [15:0] ans, ans_q;
   logic [3:0] pw_ok;
   logic lock, pw_mode, we_d, flip;
   logic [2:0] s;
   int cnt, gap;
   assign s = sector_i[2:0];
   initial begin
      pers = 8'hFF;
      pw = '{16'hFFFF, 16'hFFFF, 16'hFFFF, 16'hFFFF};
      pw_mode = 1'b0;
      {flip, we_d, cnt, gap, ans_q} = {1'b0, 1'b1, 32'd0, GAP, 16'h0};
   end
   // answer judged from the state at acceptance, before any update lands
   always_comb begin
      ans = 16'h0000;
      case (op_i)
         SWP_OP_RD_VOL: ans[8] = vol[s];
         SWP_OP_RD_PERS: ans[8] = pers[s];
         SWP_OP_RD_LOCK: ans[8] = lock;
         SWP_OP_UNLOCK: ans[0] = word_sel_i == 2'h0 && gap < GAP;
         SWP_OP_PW_PROG: ans[0] = pw_mode || |(dq_i & ~pw[word_sel_i]);
         SWP_OP_PROG_PERS, SWP_OP_ERASE_PERS: ans[0] = !lock;
         SWP_OP_MODE_PROG: ans[0] = !dq_i[1] && !dq_i[2];
         SWP_OP_PROG_ARRAY: ans[0] = !pers[s] || !vol[s] || (s == 3'h7 && !wp_pin_i);
         default: ans = 16'h0000;
      endcase
   end
   always @(posedge ref_clk_i) begin
      flip <= ~flip;
      we_d <= we_n_i;
      gap <= (gap < GAP) ? gap + 1 : gap;
      cnt <= we_n_i ? 0 : cnt + 1;
      if (!we_n_i) ans_q <= ans;
      if (!rst_n_i) begin
         vol <= {8{VOL_INIT}};
         lock <= !pw_mode;
         gap <= GAP;
         pw_ok <= 4'h0;
      end else if (!we_n_i && cnt == BUS_CYC - 1) begin
         case (op_i)
            SWP_OP_SET_VOL: vol[s] <= 1'b0;
            SWP_OP_CLR_VOL: vol[s] <= 1'b1;
            SWP_OP_SET_LOCK: lock <= 1'b0;
            SWP_OP_UNLOCK: begin
               if (word_sel_i == 2'h0) gap <= 0;
               pw_ok[word_sel_i] <= !ans[0] && dq_i == pw[word_sel_i];
               if (word_sel_i == 2'h3 && pw_mode && dq_i == pw[3] && &pw_ok[2:0]) lock <= 1'b1;
            end
            SWP_OP_PW_PROG: if (!pw_mode) pw[word_sel_i] <= pw[word_sel_i] & dq_i;
            SWP_OP_PROG_PERS: if (lock) pers[s] <= 1'b0;
            SWP_OP_ERASE_PERS: if (lock) pers <= 8'hFF;
            SWP_OP_MODE_PROG: if (dq_i[2:1] != 2'b00 && !dq_i[2]) pw_mode <= 1'b1;
            default: ;
         endcase
      end
   end
   // a released bus holds the old answer for one cycle only, so a later sample shows up
   assign dq_o = !we_n_i ? ans : (!we_d ? ans_q : ~ans_q ^ {16{flip}});
endmodule
`default_nettype wire

// ---- tb_top.sv ----
`timescale 1ns/10ps
`default_nettype none
module tb_top;
   import swp_pkg::*;
   localparam int GAP = 250;
   localparam int BC = 4;
   localparam logic [63:0] PW = 64'hF0F0_0F0F_5A5A_A5A5;
   logic ref_clk_i = 1'b0;
   logic rst_n_i = 1'b0;
   swp_cmd_t cmd = '0;
   logic [31:0] rdata, d;
   logic [15:0] dq_in, dq_out, sector;
   logic [7:0] op;
   logic [1:0] ws, res;
   logic [1:0] mode_q = 2'b00;
   logic we_n, pin, busy;
   logic pin_q = 1'b1;
   int failures = 0;
   int n_tests = 0;
   always #2 ref_clk_i = ~ref_clk_i;
   swp_host #(.UNLOCK_GAP_CYC(GAP), .BUS_CYC(BC)) u_dut (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i),
      .cmd_i(cmd), .rdata_o(rdata), .fl_dq_i(dq_in), .fl_op_o(op), .fl_sector_o(sector), .fl_word_sel_o(ws),
      .fl_dq_o(dq_out), .fl_dq_oe_o(), .fl_we_n_o(we_n), .write_protect_accel_pin_o(pin), .busy_o(busy));
   swp_flash_model #(.BUS_CYC(BC), .GAP(GAP), .VOL_INIT(1'b1)) u_flash (.ref_clk_i(ref_clk_i),
      .rst_n_i(rst_n_i), .op_i(op), .sector_i(sector), .word_sel_i(ws), .dq_i(dq_out), .we_n_i(we_n),
      .wp_pin_i(pin), .dq_o(dq_in));
   task automatic tally_and_finish;
      $display("comparisons %0d mismatches %0d", n_tests, failures);
      if (failures == 0 && n_tests > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
      n_tests++;
      if (got !== exp) begin
         failures++;
         $display("mismatch at %0t: %s got %h exp %h", $time, m, got, exp);
      end
   endtask
   task automatic wr(input logic [3:0] a, input logic [31:0] v);
      @(posedge ref_clk_i);
      cmd <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
      @(posedge ref_clk_i);
      cmd.wr <= 1'b0;
   endtask
   task automatic rd(input logic [3:0] a, output logic [31:0] v);
      @(posedge ref_clk_i);
      cmd <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
      @(posedge ref_clk_i);
      cmd.rd <= 1'b0;
      @(negedge ref_clk_i);
      v = rdata;
   endtask
   task automatic do_reset;
      @(posedge ref_clk_i);
      rst_n_i <= 1'b0;
      repeat (8) @(posedge ref_clk_i);
      rst_n_i <= 1'b1;
   endtask
   task automatic run(input logic [3:0] c, input logic [15:0] sec);
      int i;
      wr(SWP_REG_SECTOR, {16'h0, sec});
      wr(SWP_REG_CTRL, {24'h0, mode_q, pin_q, 1'b0, c});
      i = 0;
      while ((busy !== 1'b0 || i < 2) && i < 2000) begin
         @(posedge ref_clk_i);
         i++;
      end
      if (i == 2000) begin
         failures++;
         $display("mismatch at %0t: busy stuck", $time);
         tally_and_finish();
      end
      rd(SWP_REG_STATUS, d);
      res = d[1:0];
      rd(SWP_REG_RESULT, d);
   endtask
   task automatic op_ok(input logic [3:0] c, input logic [15:0] sec, input logic ok);
      run(c, sec);
      chk({31'h0, res == SWP_RES_OK}, {31'h0, ok}, "result");
   endtask
   task automatic st(input logic [3:0] c, input logic [15:0] sec, input logic exp);
      run(c, sec);
      chk({31'h0, d[8]}, {31'h0, exp}, "status bit");
   endtask
   task automatic pw_load(input logic [63:0] p);
      for (int i = 0; i < 4; i++) wr(SWP_REG_PW0 + 4'(i), {16'h0, p[16*i +: 16]});
   endtask
   task automatic t_basic;
      rd(4'h9, d);
      chk(d, 32'h0, "unmapped read");
      chk({31'h0, pin}, 32'h1, "pin after reset");
      st(SWP_CMD_VOL_RD, 16'h2, 1'b1);
      st(SWP_CMD_LOCK_RD, 16'h0, 1'b1);
      op_ok(SWP_CMD_ARRAY_PROG, 16'h3, 1'b1);
      op_ok(SWP_CMD_VOL_SET, 16'h3, 1'b1);
      st(SWP_CMD_VOL_RD, 16'h3, 1'b0);
      op_ok(SWP_CMD_ARRAY_PROG, 16'h3, 1'b0);
      op_ok(SWP_CMD_VOL_CLR, 16'h3, 1'b1);
      op_ok(SWP_CMD_ARRAY_PROG, 16'h3, 1'b1);
      rd(SWP_REG_SECTOR, d);
      chk(d, 32'h3, "sector readback");
      rd(SWP_REG_CTRL, d);
      chk(d, 32'h20, "ctrl readback");
      $display("test volatile guard done");
   endtask
   task automatic t_pers;
      op_ok(SWP_CMD_PERS_PROG, 16'h4, 1'b1);
      op_ok(SWP_CMD_ARRAY_PROG, 16'h4, 1'b0);
      op_ok(SWP_CMD_LOCK_SET, 16'h0, 1'b1);
      st(SWP_CMD_LOCK_RD, 16'h0, 1'b0);
      op_ok(SWP_CMD_PERS_ERASE, 16'h0, 1'b0);
      st(SWP_CMD_PERS_RD, 16'h4, 1'b0);
      do_reset();
      st(SWP_CMD_LOCK_RD, 16'h0, 1'b1);
      op_ok(SWP_CMD_PERS_ERASE, 16'h0, 1'b1);
      op_ok(SWP_CMD_ARRAY_PROG, 16'h4, 1'b1);
      $display("test persistent guard done");
   endtask
   task automatic t_pin;
      pin_q = 1'b0;
      op_ok(SWP_CMD_ARRAY_PROG, 16'h7, 1'b0);
      chk({31'h0, pin}, 32'h0, "pin level");
      op_ok(SWP_CMD_ARRAY_PROG, 16'h6, 1'b1);
      pin_q = 1'b1;
      op_ok(SWP_CMD_ARRAY_PROG, 16'h7, 1'b1);
      $display("test write protect pin done");
   endtask
   task automatic t_pw;
      mode_q = 2'b10;
      run(SWP_CMD_MODE_PROG, 16'h0);
      chk({30'h0, res}, {30'h0, SWP_RES_REFUSED}, "mode before password");
      mode_q = 2'b00;
      pw_load(PW);
      op_ok(SWP_CMD_PW_PROG, 16'h0, 1'b1);
      pw_load(64'hFFFF_FFFF_FFFF_FFFF);
      op_ok(SWP_CMD_PW_PROG, 16'h0, 1'b0);
      mode_q = 2'b11;
      run(SWP_CMD_MODE_PROG, 16'h0);
      chk({30'h0, res}, {30'h0, SWP_RES_ABORT}, "double mode");
      mode_q = 2'b10;
      op_ok(SWP_CMD_MODE_PROG, 16'h0, 1'b1);
      mode_q = 2'b00;
      do_reset();
      st(SWP_CMD_LOCK_RD, 16'h0, 1'b0);
      pw_load(PW ^ 64'h1);
      run(SWP_CMD_PW_UNLOCK, 16'h0);
      st(SWP_CMD_LOCK_RD, 16'h0, 1'b0);
      pw_load(PW);
      run(SWP_CMD_PW_UNLOCK, 16'h0);
      st(SWP_CMD_LOCK_RD, 16'h0, 1'b1);
      op_ok(SWP_CMD_PW_PROG, 16'h0, 1'b0);
      $display("test password done");
   endtask
   initial begin
      repeat (8) @(posedge ref_clk_i);
      rst_n_i <= 1'b1;
      t_basic();
      t_pers();
      t_pin();
      t_pw();
      tally_and_finish();
   end
endmodule
`default_nettype wire
